/* dual_channel_input_capture.sv */
// Purpose: two-channel input capture with latching, rollover and status
// Assumes: strobes one cycle long; read data registered one cycle later
// Notes: channel one is array index 0, channel two is index 1
//
// What this block does
// - two channels, each with a 16-bit counter advanced once per tick
// - capture pins resampled on the tick, so requests come late
// - status flag sets in the same cycle the interrupt request rises
// - start and stop pins each chosen from bit 1,3,5,7 of four ports
// - each input disabled, rising, falling or either-edge sensitive
// - either condition may request interrupt and may latch the count
// - counter only cleared by software reset command
// - wrap from all ones to zero sets rollover bit, no interrupt
// - low byte read snapshots high byte for the later high read
// - start-stop mode counts from start condition until stop condition
// - one count latch per channel, overwritten by each latch event
// - free mode counts always, conditions only latch the count
// - until-stop mode halts at stop until software rewrites trigger
// - status bits 7..4 report ch2 start, ch2 stop, ch1 start, ch1 stop
// - status bit 3 reports ch2 rollover, bit 2 ch1 rollover
// - status read clears bits 7..2 and the interrupt, not enables
// - write bits 7..4 set the four condition interrupt enables
// - writing one to bit 3 or 2 zeroes counter and rollover
// - bits 1:0 equal 11 gives test mode, bytes count without carry
// - trigger bits 7:6 choose off, start-stop, free, until-stop
// - trigger bits 5:4 choose latch on none, stop, start, either
// - trigger bits 3:2 start edge, 1:0 stop edge
// - select bits choose port and bit for start and stop
`timescale 1ns/1ns
module dual_channel_input_capture #(
  parameter int TICK_DIV = capture_pkg::TICK_DIV_DEFAULT
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [7:0] port_c_i,
  input wire logic [7:0] port_d_i,
  input wire logic [7:0] port_f_i,
  input wire logic [7:0] port_g_i,
  output logic irq_o,
  output logic [1:0] irq_priority_o
);
  import capture_pkg::*;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // edge match for one condition
  function automatic logic edge_hit(input logic [1:0] sel, input logic rise,
                                    input logic fall);
    edge_hit = (sel[0] & rise) | (sel[1] & fall);
  endfunction : edge_hit

  // next counter value, carry broken in test mode
  function automatic logic [15:0] bump(input logic [15:0] cnt, input logic test);
    logic [15:0] res;
    res = cnt + 16'h0001;
    if (test) begin
      res = {cnt[15:8] + 8'h01, cnt[7:0] + 8'h01};
    end
    bump = res;
  endfunction : bump

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic rst_meta_n;
  logic rst_n;
  logic tick;
  logic [3:0] irq_en;
  logic [1:0] test_sel;
  logic [1:0] prio;
  logic [7:0] trig [2];
  logic [7:0] src [2];
  logic [1:0] start_rise;
  logic [1:0] start_fall;
  logic [1:0] stop_rise;
  logic [1:0] stop_fall;
  logic [1:0] start_ev;
  logic [1:0] stop_ev;
  logic [1:0] trig_wr;
  logic [1:0] sw_clear;
  logic [1:0] count_en;
  logic [1:0] wrap;
  logic [1:0] latch_ev;
  logic [1:0] mode [2];
  logic [1:0] latch_sel [2];
  run_state_t run_st [2];
  run_state_t next_run_st [2];
  logic [15:0] count [2];
  logic [15:0] latched [2];
  logic [7:0] high_hold [2];
  logic [3:0] cond_flags;
  logic [3:0] cond_set;
  logic [1:0] rollover;
  logic status_rd;
  logic test_on;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  // asynchronous assert, two-flop synchronous release
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // ----------------------------------------------------------------
  // tick and pin selection
  // ----------------------------------------------------------------
  capture_tick_divider #(
    .DIV(TICK_DIV)
  ) u_tick (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .tick_o(tick)
  );

  // one selector per condition of each channel
  for (genvar c = 0; c < 2; c++) begin : g_chan
    capture_input_sel u_start (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n),
      .tick_i(tick),
      .port_c_i(port_c_i),
      .port_d_i(port_d_i),
      .port_f_i(port_f_i),
      .port_g_i(port_g_i),
      .port_sel_i(src[c][SEL_START_PORT_LSB +: 2]),
      .bit_sel_i(src[c][SEL_START_BIT_LSB +: 2]),
      .rise_o(start_rise[c]),
      .fall_o(start_fall[c])
    );
    capture_input_sel u_stop (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n),
      .tick_i(tick),
      .port_c_i(port_c_i),
      .port_d_i(port_d_i),
      .port_f_i(port_f_i),
      .port_g_i(port_g_i),
      .port_sel_i(src[c][SEL_STOP_PORT_LSB +: 2]),
      .bit_sel_i(src[c][SEL_STOP_BIT_LSB +: 2]),
      .rise_o(stop_rise[c]),
      .fall_o(stop_fall[c])
    );
  end

  // ----------------------------------------------------------------
  // decode and condition events
  // ----------------------------------------------------------------
  // strobe decode plus per-channel events
  always_comb begin
    status_rd = rd_i && (addr_i == ADDR_CTRL_STATUS);
    trig_wr[0] = wr_i && (addr_i == ADDR_CH1_TRIGGER);
    trig_wr[1] = wr_i && (addr_i == ADDR_CH2_TRIGGER);
    sw_clear[0] = wr_i && (addr_i == ADDR_CTRL_STATUS) && wdata_i[CS_RESET_CH1];
    sw_clear[1] = wr_i && (addr_i == ADDR_CTRL_STATUS) && wdata_i[CS_RESET_CH2];
    test_on = (test_sel == TEST_MODE);
    for (int c = 0; c < 2; c++) begin
      mode[c] = trig[c][TRIG_MODE_LSB +: 2];
      latch_sel[c] = trig[c][TRIG_LATCH_LSB +: 2];
      start_ev[c] = edge_hit(trig[c][TRIG_START_LSB +: 2], start_rise[c],
                             start_fall[c]);
      stop_ev[c] = edge_hit(trig[c][TRIG_STOP_LSB +: 2], stop_rise[c],
                            stop_fall[c]);
      latch_ev[c] = (latch_sel[c][0] & stop_ev[c]) |
                    (latch_sel[c][1] & start_ev[c]);
      count_en[c] = tick && (run_st[c] == ST_RUN) && (mode[c] != MODE_OFF);
      wrap[c] = count_en[c] && (count[c] == COUNT_MAX);
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  // control/status write side: enables and test field
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_en <= RST_CTRL_STATUS[7:4];
      test_sel <= RST_CTRL_STATUS[1:0];
    end else if (wr_i && (addr_i == ADDR_CTRL_STATUS)) begin
      irq_en <= wdata_i[7:4];
      test_sel <= wdata_i[1:0];
    end
  end

  // interrupt priority register
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prio <= RST_IRQ_PRIORITY;
    end else if (wr_i && (addr_i == ADDR_IRQ_PRIORITY)) begin
      prio <= wdata_i[1:0];
    end
  end

  // trigger and select registers of both channels
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      trig[0] <= RST_TRIGGER;
      trig[1] <= RST_TRIGGER;
      src[0] <= RST_SELECT;
      src[1] <= RST_SELECT;
    end else if (wr_i) begin
      case (addr_i)
        ADDR_CH1_TRIGGER: trig[0] <= wdata_i;
        ADDR_CH2_TRIGGER: trig[1] <= wdata_i;
        ADDR_CH1_SELECT: src[0] <= wdata_i;
        ADDR_CH2_SELECT: src[1] <= wdata_i;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // run state
  // ----------------------------------------------------------------
  // stop beats start when both land on one tick
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      next_run_st[c] = run_st[c];
      case (run_st[c])
        ST_IDLE: begin
          if ((mode[c] == MODE_FREE) || (mode[c] == MODE_UNTIL_STOP)) begin
            next_run_st[c] = ST_RUN;
          end else if ((mode[c] == MODE_START_STOP) && start_ev[c] && !stop_ev[c]) begin
            next_run_st[c] = ST_RUN;
          end
        end
        ST_RUN: begin
          if (mode[c] == MODE_OFF) begin
            next_run_st[c] = ST_IDLE;
          end else if ((mode[c] == MODE_START_STOP) && stop_ev[c]) begin
            next_run_st[c] = ST_IDLE;
          end else if ((mode[c] == MODE_UNTIL_STOP) && stop_ev[c]) begin
            next_run_st[c] = ST_HALT;
          end
        end
        ST_HALT: next_run_st[c] = ST_HALT;
        default: next_run_st[c] = ST_IDLE;
      endcase
      // a trigger write re-arms the channel
      if (trig_wr[c]) begin
        next_run_st[c] = ST_IDLE;
      end
    end
  end

  // run state flops
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      run_st[0] <= ST_IDLE;
      run_st[1] <= ST_IDLE;
    end else begin
      run_st[0] <= next_run_st[0];
      run_st[1] <= next_run_st[1];
    end
  end

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  // only the software command zeroes a counter
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      count[0] <= 16'h0000;
      count[1] <= 16'h0000;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (sw_clear[c]) begin
          count[c] <= 16'h0000;
        end else if (count_en[c]) begin
          count[c] <= bump(count[c], test_on);
        end
      end
    end
  end

  // rollover latches; a wrap wins over a clear in the same cycle
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rollover <= 2'h0;
    end else begin
      rollover <= (rollover & ~sw_clear & ~{2{status_rd}}) | wrap;
    end
  end

  // ----------------------------------------------------------------
  // count latch and stale-data hold
  // ----------------------------------------------------------------
  // newest latch event always overwrites
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      latched[0] <= 16'h0000;
      latched[1] <= 16'h0000;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (latch_ev[c]) begin
          latched[c] <= count[c];
        end
      end
    end
  end

  // low byte read freezes the matching high byte
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      high_hold[0] <= 8'h00;
      high_hold[1] <= 8'h00;
    end else if (rd_i && (addr_i == ADDR_CH1_LOW)) begin
      high_hold[0] <= latched[0][15:8];
    end else if (rd_i && (addr_i == ADDR_CH2_LOW)) begin
      high_hold[1] <= latched[1][15:8];
    end
  end

  // ----------------------------------------------------------------
  // status flags and interrupt
  // ----------------------------------------------------------------
  // condition flags in status bit order 7..4
  assign cond_set = {start_ev[1], stop_ev[1], start_ev[0], stop_ev[0]};

  // set beats the read clear in the same cycle
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cond_flags <= 4'h0;
    end else begin
      cond_flags <= (cond_flags & ~{4{status_rd}}) | cond_set;
    end
  end

  // request follows the flags in the same cycle they set
  assign irq_o = (|(cond_flags & irq_en)) && (prio != 2'h0);
  assign irq_priority_o = prio;

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // read data valid in the cycle after the strobe only
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        ADDR_CTRL_STATUS: rdata_o <= {cond_flags, rollover, 2'h0};
        ADDR_CH1_LOW: rdata_o <= latched[0][7:0];
        ADDR_CH1_HIGH: rdata_o <= high_hold[0];
        ADDR_CH2_LOW: rdata_o <= latched[1][7:0];
        ADDR_CH2_HIGH: rdata_o <= high_hold[1];
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

endmodule : dual_channel_input_capture

/* capture_pkg.sv */
// Purpose: shared constants and types of the dual channel input capture unit
// Assumes: 8-bit register port with byte-wide offsets
// Notes: channel one is index 0, channel two is index 1
package capture_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL_STATUS = 8'h56;
  localparam logic [7:0] ADDR_IRQ_PRIORITY = 8'h57;
  localparam logic [7:0] ADDR_CH1_TRIGGER = 8'h58;
  localparam logic [7:0] ADDR_CH1_SELECT = 8'h59;
  localparam logic [7:0] ADDR_CH1_LOW = 8'h5a;
  localparam logic [7:0] ADDR_CH1_HIGH = 8'h5b;
  localparam logic [7:0] ADDR_CH2_TRIGGER = 8'h5c;
  localparam logic [7:0] ADDR_CH2_SELECT = 8'h5d;
  localparam logic [7:0] ADDR_CH2_LOW = 8'h5e;
  localparam logic [7:0] ADDR_CH2_HIGH = 8'h5f;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CTRL_STATUS = 8'h00;
  localparam logic [1:0] RST_IRQ_PRIORITY = 2'h0;
  localparam logic [7:0] RST_TRIGGER = 8'h00;
  localparam logic [7:0] RST_SELECT = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CS_RESET_CH2 = 3;
  localparam int CS_RESET_CH1 = 2;
  localparam int TRIG_MODE_LSB = 6;
  localparam int TRIG_LATCH_LSB = 4;
  localparam int TRIG_START_LSB = 2;
  localparam int TRIG_STOP_LSB = 0;
  localparam int SEL_START_PORT_LSB = 6;
  localparam int SEL_START_BIT_LSB = 4;
  localparam int SEL_STOP_PORT_LSB = 2;
  localparam int SEL_STOP_BIT_LSB = 0;

  // ----------------------------------------------------------------
  // field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_START_STOP = 2'h1;
  localparam logic [1:0] MODE_FREE = 2'h2;
  localparam logic [1:0] MODE_UNTIL_STOP = 2'h3;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [1:0] TEST_MODE = 2'h3;
  localparam logic [15:0] COUNT_MAX = 16'hffff;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int TICK_DIV_DEFAULT = 1; // ref clocks per counter tick

  // per-channel run state
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_HALT = 3'b100
  } run_state_t;

endpackage : capture_pkg

/* capture_tick_divider.sv */
// Purpose: makes the one-cycle count tick that paces the capture unit
// Assumes: DIV of at least one
// Notes: with DIV of one the tick is high every cycle
`timescale 1ns/1ns
module capture_tick_divider #(
  parameter int DIV = capture_pkg::TICK_DIV_DEFAULT
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  output logic tick_o
);
  import capture_pkg::*;

  logic [15:0] div_cnt;

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  // wraps at DIV-1 and pulses the tick
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_cnt <= 16'h0000;
    end else if (div_cnt == 16'(DIV - 1)) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  assign tick_o = (div_cnt == 16'(DIV - 1));

endmodule : capture_tick_divider

/* capture_input_sel.sv */
// Purpose: picks one capture pin, resamples it on the tick, finds its edges
// Assumes: port pins synchronous to the clock
// Notes: edge pulses last one cycle, on a tick cycle only
`timescale 1ns/1ns
module capture_input_sel (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic tick_i,
  input wire logic [7:0] port_c_i,
  input wire logic [7:0] port_d_i,
  input wire logic [7:0] port_f_i,
  input wire logic [7:0] port_g_i,
  input wire logic [1:0] port_sel_i,
  input wire logic [1:0] bit_sel_i,
  output logic rise_o,
  output logic fall_o
);
  import capture_pkg::*;

  logic [7:0] port_val;
  logic pin;
  logic samp1;
  logic samp2;
  logic samp3;

  // port then odd bit 1, 3, 5 or 7
  always_comb begin
    case (port_sel_i)
      2'h0: port_val = port_c_i;
      2'h1: port_val = port_d_i;
      2'h2: port_val = port_f_i;
      default: port_val = port_g_i;
    endcase
    pin = port_val[{bit_sel_i, 1'b1}];
  end

  // ----------------------------------------------------------------
  // tick-paced resampling
  // ----------------------------------------------------------------
  // samp1 feeds only samp2; edges compare samp2 and samp3
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      samp1 <= 1'b0;
      samp2 <= 1'b0;
      samp3 <= 1'b0;
    end else if (tick_i) begin
      samp1 <= pin;
      samp2 <= samp1;
      samp3 <= samp2;
    end
  end

  assign rise_o = tick_i & samp2 & ~samp3;
  assign fall_o = tick_i & ~samp2 & samp3;

endmodule : capture_input_sel

/* capture_props.sv */
// Purpose: port-level assertions for the dual channel input capture unit
// Assumes: TICK_DIV of one, strobes never together
// Notes: quiet counts cycles since a usable pin last moved
`timescale 1ns/1ns
module capture_props (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic [7:0] port_c_i,
  input wire logic [7:0] port_d_i,
  input wire logic [7:0] port_f_i,
  input wire logic [7:0] port_g_i,
  input wire logic irq_o,
  input wire logic [1:0] irq_priority_o
);
  logic [31:0] pins;
  logic [31:0] pins_q;
  logic [2:0] quiet;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);
  // only odd pins can be selected
  assign pins = {port_g_i, port_f_i, port_d_i, port_c_i} & {4{8'haa}};
  // saturating count of cycles with no pin change
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pins_q <= 32'h0;
      quiet <= 3'h0;
    end else begin
      pins_q <= pins;
      quiet <= (pins != pins_q) ? 3'h0 : (quiet == 3'h7) ? 3'h7 : quiet + 3'h1;
    end
  end
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not idle");
  a_status_low_zero: assert property (rd_i && addr_i == 8'h56 |=> rdata_o[1:0] == 2'h0)
    else $error("status low bits not zero");
  a_read_clears_irq: assert property (rd_i && addr_i == 8'h56 && quiet == 3'h7 |=> !irq_o)
    else $error("status read left request up");
  a_irq_needs_prio: assert property (irq_priority_o == 2'h0 |-> !irq_o)
    else $error("request with priority zero");
  a_prio_written: assert property (wr_i && addr_i == 8'h57 |=>
    {6'h0, irq_priority_o} == ($past(wdata_i) & 8'h03))
    else $error("priority not taken");
  a_prio_holds: assert property (!(wr_i && addr_i == 8'h57) |=> $stable(irq_priority_o))
    else $error("priority moved without write");
  a_enables_off: assert property (wr_i && addr_i == 8'h56 && wdata_i[7:4] == 4'h0
    |=> !irq_o [*2])
    else $error("request with enables off");
  a_irq_after_pin: assert property ($rose(irq_o) && !$past(wr_i) |-> quiet <= 3'h5)
    else $error("request without pin edge");
endmodule : capture_props

/* pin_model.sv */
// Purpose: drives the four parallel ports seen by the capture unit
// Assumes: commands given by non-blocking assignment after an edge
// Notes: unused even bits toggle every cycle to expose a wrong bit pick
`timescale 1ns/1ns
module pin_model (
  input wire logic clk_i,
  input wire logic set_i,
  input wire logic [1:0] port_i,
  input wire logic [1:0] bit_i,
  input wire logic level_i,
  output logic [7:0] port_c_o,
  output logic [7:0] port_d_o,
  output logic [7:0] port_f_o,
  output logic [7:0] port_g_o
);
  logic [31:0] pins = 32'h0;
  logic even = 1'b0;
  // odd pins follow commands, even pins churn
  always @(posedge clk_i) begin
    even <= ~even;
    if (set_i) begin
      pins[{port_i, bit_i, 1'b1}] <= level_i;
    end
  end
  assign port_c_o = (pins[7:0] & 8'haa) | {4{1'b0, even}};
  assign port_d_o = (pins[15:8] & 8'haa) | {4{1'b0, even}};
  assign port_f_o = (pins[23:16] & 8'haa) | {4{1'b0, even}};
  assign port_g_o = (pins[31:24] & 8'haa) | {4{1'b0, even}};
endmodule : pin_model

/* tb_top.sv */
// Purpose: self-checking bench for the dual channel input capture unit
// Assumes: TICK_DIV of one, so one count per clock
// Notes: reads queue their expected data, a monitor compares
`timescale 1ns/1ns
module tb_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_q = 1'b0;
  logic [7:0] rdata;
  logic [7:0] pc, pd, pf, pg;
  logic irq;
  logic [1:0] prio;
  logic set = 1'b0;
  logic [1:0] psel = 2'h0;
  logic [1:0] bsel = 2'h0;
  logic lvl = 1'b0;
  logic [7:0] exp_q [$];
  logic [7:0] addrs [12] = '{8'h56, 8'h57, 8'h58, 8'h59, 8'h5a, 8'h5b,
    8'h5c, 8'h5d, 8'h5e, 8'h5f, 8'h55, 8'h60};
  logic [15:0] v1, v2;
  int failures = 0;
  int comparisons = 0;
  int n;
  dual_channel_input_capture #(.TICK_DIV(1)) dual_channel_input_capture_inst (
    .ref_clk_i(clk), .resetn_i(resetn), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .port_c_i(pc), .port_d_i(pd), .port_f_i(pf),
    .port_g_i(pg), .irq_o(irq), .irq_priority_o(prio));
  pin_model pin_model_inst (.clk_i(clk), .set_i(set), .port_i(psel), .bit_i(bsel),
    .level_i(lvl), .port_c_o(pc), .port_d_o(pd), .port_f_o(pf), .port_g_o(pg));
  initial begin
    forever #50 clk = ~clk;
  end
  // ----
  // tasks
  // ----
  task finish_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  task check(input logic [7:0] seen, input logic [7:0] want);
    comparisons++;
    if (seen !== want) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, seen, want);
    end
  endtask : check
  task wrr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrr
  task rdr(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask : rdr
  task pin(input int p, input int b, input logic l);
    @(posedge clk);
    set <= 1'b1;
    psel <= p[1:0];
    bsel <= b[1:0];
    lvl <= l;
    @(posedge clk);
    set <= 1'b0;
  endtask : pin
  // pin high for w+2 cycles, then settle
  task pulse(input int p, input int b, input int w);
    pin(p, b, 1'b1);
    repeat (w) @(posedge clk);
    pin(p, b, 1'b0);
    repeat (8) @(posedge clk);
  endtask : pulse
  // read data stands only in the cycle after the strobe
  always @(posedge clk) rd_q <= rd;
  always @(negedge clk) begin
    if (rd_q) begin
      if (exp_q.size() == 0) begin
        failures++;
        $display("unexpected at %0t: read data with no expected value", $time);
      end else check(rdata, exp_q.pop_front());
    end
  end
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    finish_test();
  end
  // ----
  // main sequence
  // ----
  initial begin
    void'($urandom(3));
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    // reset values, write-only and unmapped places read zero
    foreach (addrs[i]) rdr(addrs[i], 8'h00);
    check({6'h0, prio}, 8'h00);
    // test mode rollover of both channels, no request
    wrr(8'h57, 8'h01);
    wrr(8'h5c, 8'h80);
    wrr(8'h58, 8'h80);
    wrr(8'h56, 8'hff);
    repeat (300) @(posedge clk);
    @(negedge clk);
    check({7'h0, irq}, 8'h00);
    rdr(8'h56, 8'h0c);
    rdr(8'h56, 8'h00);
    wrr(8'h56, 8'h00);
    // every port and bit as channel two start
    wrr(8'h5c, 8'h04);
    for (int p = 0; p < 4; p++) begin
      for (int b = 0; b < 4; b++) begin
        wrr(8'h5d, {p[1:0], b[1:0], 4'h0});
        pulse(p, b, 6);
        rdr(8'h56, 8'h80);
      end
    end
    // every edge select on start and stop from one pin
    wrr(8'h5d, 8'h66);
    for (int e = 0; e < 4; e++) begin
      wrr(8'h5c, {4'h0, e[1:0], e[1:0]});
      pin(1, 2, 1'b1);
      repeat (8) @(posedge clk);
      rdr(8'h56, e[0] ? 8'hc0 : 8'h00);
      pin(1, 2, 1'b0);
      repeat (8) @(posedge clk);
      rdr(8'h56, e[1] ? 8'hc0 : 8'h00);
    end
    // enabled start raises the request, stop flag without enable does not
    wrr(8'h57, 8'h02);
    wrr(8'h5d, 8'h6f);
    wrr(8'h5c, 8'h86);
    wrr(8'h56, 8'h80);
    pin(1, 2, 1'b1);
    for (n = 0; n < 40 && irq !== 1'b1; n++) @(posedge clk);
    if (irq !== 1'b1) begin
      failures++;
      finish_test();
    end
    check({6'h0, prio}, 8'h02);
    repeat (8) @(posedge clk);
    rdr(8'h56, 8'h80);
    repeat (2) @(posedge clk);
    @(negedge clk);
    check({7'h0, irq}, 8'h00);
    pin(1, 2, 1'b0);
    pulse(3, 3, 8);
    @(negedge clk);
    check({7'h0, irq}, 8'h00);
    rdr(8'h56, 8'h40);
    // start-stop pulse width on one pin, held high byte, overwrite
    wrr(8'h59, 8'h11);
    wrr(8'h58, 8'h56);
    wrr(8'h56, 8'h04);
    n = $urandom_range(511, 256);
    v1 = 16'(n + 1);
    pulse(0, 1, n);
    rdr(8'h5a, v1[7:0]);
    wrr(8'h56, 8'h04);
    n = $urandom_range(200, 2);
    v2 = 16'(n + 1);
    pulse(0, 1, n);
    rdr(8'h5b, v1[15:8]);
    rdr(8'h5a, v2[7:0]);
    rdr(8'h5b, v2[15:8]);
    // until-stop, latch on either condition, count frozen after stop
    wrr(8'h59, 8'h02);
    wrr(8'h58, 8'hf5);
    wrr(8'h56, 8'h04);
    repeat (300) @(posedge clk);
    pin(0, 0, 1'b1);
    repeat (8) @(posedge clk);
    rdr(8'h5a, 8'h30);
    rdr(8'h5b, 8'h01);
    pin(0, 2, 1'b1);
    repeat (20) @(posedge clk);
    pin(0, 0, 1'b0);
    pin(0, 0, 1'b1);
    repeat (8) @(posedge clk);
    rdr(8'h5a, 8'h3f);
    rdr(8'h5b, 8'h01);
    rdr(8'h56, 8'h30);
    repeat (4) @(posedge clk);
    finish_test();
  end
endmodule : tb_top
bind dual_channel_input_capture capture_props capture_props_inst (
  .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .port_c_i(port_c_i), .port_d_i(port_d_i),
  .port_f_i(port_f_i), .port_g_i(port_g_i), .irq_o(irq_o), .irq_priority_o(irq_priority_o));
